// >>> sacc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
// byte offsets
`define SACC_OFS_SC1        8'h00
`define SACC_OFS_SC2        8'h04
`define SACC_OFS_RES_HI     8'h08
`define SACC_OFS_RES_LO     8'h0C
`define SACC_OFS_CMP_HI     8'h10
`define SACC_OFS_CMP_LO     8'h14
`define SACC_OFS_CFG        8'h18
// status_control_one fields
`define SACC_SC1_DONE       7
`define SACC_SC1_IEN        6
`define SACC_SC1_CONT       5
`define SACC_SC1_CH_HI      4
// status_control_two fields
`define SACC_SC2_ACTIVE     7
`define SACC_SC2_HWTRG      6
`define SACC_SC2_CMPEN      5
`define SACC_SC2_CMPGE      4
// configuration fields
`define SACC_CFG_LOWPWR     7
`define SACC_CFG_DIV_HI     6
`define SACC_CFG_DIV_LO     5
`define SACC_CFG_LONGSMP    4
`define SACC_CFG_MODE8      2
`define SACC_CFG_SRC_HI     1
`define SACC_CFG_SRC_LO     0
// reset values
`define SACC_SC1_RESET      8'h1F
`define SACC_CH_OFF         5'h1F
// sample lengths in conversion clocks
`define SACC_SMP_SHORT      4'h3
`define SACC_SMP_LONG       4'hF
`define SACC_SMP_EXTRA_HS   4'h2
`endif

// >>> sacc_pkg.sv
// shared types of the converter control
package sacc_pkg;
    typedef enum logic [1:0] {
        SACC_SRC_BUS,
        SACC_SRC_BUS_HALF,
        SACC_SRC_LOCAL,
        SACC_SRC_ALT
    } sacc_src_e;
    typedef enum logic [1:0] {
        SACC_IDLE,
        SACC_SAMPLE,
        SACC_APPROX
    } sacc_state_e;
endpackage

// >>> sacc_clk_if.sv
// conversion clock enable interface between divider and sequencer
`timescale 1ns/100ps
interface sacc_clk_if;
    logic [1:0] src;
    logic [1:0] div;
    logic       run;
    logic       tick;
    modport gen (input src, input div, input run, output tick);
    modport use_ (output src, output div, output run, input tick);
endinterface

// >>> sacc_clkgen.sv
// conversion clock enable generator: source select and divider
`timescale 1ns/100ps
module sacc_clkgen #(
    parameter int LOCAL_DIV = 4
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  alt_clk_sync,
    sacc_clk_if.gen    cif
);
    // =========================================
    // source pulses
    logic       half_reg;
    logic [3:0] local_reg;
    logic       alt_prev_reg;
    logic [2:0] div_reg;
    wire        alt_edge   = alt_clk_sync & ~alt_prev_reg;
    wire        local_tick = (local_reg == 4'(LOCAL_DIV - 1));
    logic       src_tick;
    always_comb begin
        unique case (sacc_pkg::sacc_src_e'(cif.src))
            sacc_pkg::SACC_SRC_BUS:      src_tick = 1'b1;
            sacc_pkg::SACC_SRC_BUS_HALF: src_tick = half_reg;
            sacc_pkg::SACC_SRC_LOCAL:    src_tick = local_tick;
            sacc_pkg::SACC_SRC_ALT:      src_tick = alt_edge;
        endcase
    end
    // =========================================
    // divide by 1,2,4,8
    wire [2:0] div_mask = 3'((4'h1 << cif.div) - 4'h1);
    wire       div_hit  = ((div_reg & div_mask) == div_mask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_reg     <= 1'b0;
            local_reg    <= 4'h0;
            alt_prev_reg <= 1'b0;
            div_reg      <= 3'h0;
            cif.tick     <= 1'b0;
        end else begin
            half_reg     <= ~half_reg;
            local_reg    <= local_tick ? 4'h0 : local_reg + 4'h1;
            alt_prev_reg <= alt_clk_sync;
            cif.tick     <= 1'b0;
            if (!cif.run) begin
                div_reg <= 3'h0;
            end else if (src_tick) begin
                div_reg  <= div_hit ? 3'h0 : div_reg + 3'h1;
                cif.tick <= div_hit;
            end
        end
    end
endmodule

// >>> sacc_sar.sv
// successive-approximation bit sequencer
`timescale 1ns/100ps
module sacc_sar #(
    parameter int RES_W = 10
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             tick,
    input  wire logic             comp_in,
    output logic [RES_W-1:0]      trial,
    output logic                  done,
    output logic [RES_W-1:0]      result
);
    logic [RES_W-1:0] bit_reg;
    logic             busy_reg;
    logic [1:0]       wait_reg;
    wire  [RES_W-1:0] kept = comp_in ? trial : (trial & ~bit_reg);
    wire  [RES_W-1:0] top  = {1'b1, {(RES_W-1){1'b0}}};
    // =========================================
    // one bit per trial, msb first, on the first conversion clock after a three-cycle wait for the synchronised comparator to settle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_reg  <= '0;
            trial    <= '0;
            busy_reg <= 1'b0;
            done     <= 1'b0;
            result   <= '0;
            wait_reg <= 2'h0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy_reg <= 1'b0;
            end else if (start) begin
                bit_reg  <= top;
                trial    <= top;
                busy_reg <= 1'b1;
                wait_reg <= 2'h3;
            end else if (busy_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (busy_reg && tick) begin
                wait_reg <= 2'h3;
                bit_reg  <= bit_reg >> 1;
                trial    <= kept | (bit_reg >> 1);
                if (bit_reg[0]) begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                    result   <= kept;
                end
            end
        end
    end
endmodule

// >>> sacc_top.sv
// SAR converter control with AXI4-Lite registers
`timescale 1ns/100ps
`include "sacc_regs.svh"
module sacc_top #(
    parameter int RES_W     = 10,
    parameter int LOCAL_DIV = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        alternate_clock_input,
    input  wire logic        hardware_trigger_input,
    input  wire logic        comparator_in,
    output logic [4:0]       channel_select,
    output logic             sample_enable,
    output logic             long_sample,
    output logic             low_power,
    output logic [RES_W-1:0] dac_trial,
    output logic             conv_irq
);
    // =========================================
    // registers
    logic [7:0]       sc1_reg;
    logic [7:0]       sc2_reg;
    logic [7:0]       cfg_reg;
    logic [RES_W-1:0] cmp_reg;
    logic [RES_W-1:0] res_reg;
    logic [3:0]       smp_cnt_reg;
    logic             hw_armed_reg;
    sacc_pkg::sacc_state_e st_reg;
    // =========================================
    // pin synchronisers
    logic [1:0] alt_sync_reg;
    logic [1:0] trg_sync_reg;
    logic [1:0] cmp_sync_reg;
    logic       trg_prev_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_sync_reg <= 2'b00;
            trg_sync_reg <= 2'b00;
            cmp_sync_reg <= 2'b00;
            trg_prev_reg <= 1'b0;
        end else begin
            alt_sync_reg <= {alt_sync_reg[0], alternate_clock_input};
            trg_sync_reg <= {trg_sync_reg[0], hardware_trigger_input};
            cmp_sync_reg <= {cmp_sync_reg[0], comparator_in};
            trg_prev_reg <= trg_sync_reg[1];
        end
    end
    // overflow pulse only, interrupt enable of counter not involved
    wire hw_event = trg_sync_reg[1] & ~trg_prev_reg;
    // =========================================
    // AXI4-Lite write path
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    wire         aw_fire = s_axi_awvalid & s_axi_awready;
    wire         w_fire  = s_axi_wvalid & s_axi_wready;
    wire         wr_go   = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire         wr_b0   = wr_go & w_strb_reg[0];
    wire         wr_sc1  = wr_b0 & (aw_addr_reg == `SACC_OFS_SC1);
    wire         wr_sc2  = wr_b0 & (aw_addr_reg == `SACC_OFS_SC2);
    wire         wr_cmph = wr_b0 & (aw_addr_reg == `SACC_OFS_CMP_HI);
    wire         wr_cmpl = wr_b0 & (aw_addr_reg == `SACC_OFS_CMP_LO);
    wire         wr_cfg  = wr_b0 & (aw_addr_reg == `SACC_OFS_CFG);
    wire         wr_ok   = (aw_addr_reg <= `SACC_OFS_CFG) & (aw_addr_reg[1:0] == 2'b00);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~aw_fire;
            s_axi_wready  <= ~w_got_reg & ~w_fire;
            if (aw_fire) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_reg    <= 1'b0;
                w_got_reg     <= 1'b0;
            end
        end
    end
    // =========================================
    // AXI4-Lite read path
    wire       rd_fire = s_axi_arvalid & s_axi_arready;
    wire       rd_lo   = rd_fire & (s_axi_araddr == `SACC_OFS_RES_LO);
    wire [7:0] res_hi  = cfg_reg[`SACC_CFG_MODE8] ? 8'h00 : {6'h00, res_reg[9:8]};
    wire [7:0] res_lo  = cfg_reg[`SACC_CFG_MODE8] ? res_reg[9:2] : res_reg[7:0];
    logic [7:0] rd_mux;
    logic       rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `SACC_OFS_SC1:    rd_mux = sc1_reg;
            `SACC_OFS_SC2:    rd_mux = {(st_reg != sacc_pkg::SACC_IDLE), sc2_reg[6:0]};
            `SACC_OFS_RES_HI: rd_mux = res_hi;
            `SACC_OFS_RES_LO: rd_mux = res_lo;
            `SACC_OFS_CMP_HI: rd_mux = {6'h00, cmp_reg[9:8]};
            `SACC_OFS_CMP_LO: rd_mux = cmp_reg[7:0];
            `SACC_OFS_CFG:    rd_mux = cfg_reg;
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rd_mux};
                s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // =========================================
    // conversion clock and sequencer
    sacc_clk_if cif ();
    wire               conv_tick;
    wire               sar_done;
    wire [RES_W-1:0]   sar_result;
    wire [RES_W-1:0]   sar_trial;
    wire               ch_off    = (sc1_reg[4:0] == `SACC_CH_OFF);
    wire               new_off   = (w_data_reg[4:0] == `SACC_CH_OFF);
    wire               sw_start  = wr_sc1 & ~new_off & ~sc2_reg[`SACC_SC2_HWTRG];
    wire               hw_start  = hw_event & sc2_reg[`SACC_SC2_HWTRG] & ~ch_off
                                   & (st_reg == sacc_pkg::SACC_IDLE)
                                   & (hw_armed_reg | sc1_reg[`SACC_SC1_CONT]);
    wire               cont_next = sar_done & sc1_reg[`SACC_SC1_CONT] & ~ch_off
                                   & ~sc2_reg[`SACC_SC2_HWTRG];
    wire               go        = sw_start | ((hw_start | cont_next) & ~wr_sc1);
    wire               abort     = wr_sc1;
    wire [3:0]         smp_len   = (cfg_reg[`SACC_CFG_LONGSMP] ? `SACC_SMP_LONG
                                   : `SACC_SMP_SHORT)
                                   - (cfg_reg[`SACC_CFG_LOWPWR] ? 4'h0 : `SACC_SMP_EXTRA_HS);
    wire               cmp_lt    = sar_result < cmp_reg;
    wire               cmp_true  = sc2_reg[`SACC_SC2_CMPGE] ? ~cmp_lt : cmp_lt;
    wire               set_done  = sar_done & (~sc2_reg[`SACC_SC2_CMPEN] | cmp_true);
    wire               smp_end   = (st_reg == sacc_pkg::SACC_SAMPLE) & conv_tick
                                   & (smp_cnt_reg == 4'h0);
    assign cif.src = cfg_reg[`SACC_CFG_SRC_HI:`SACC_CFG_SRC_LO];
    assign cif.div = cfg_reg[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
    assign cif.run = (st_reg != sacc_pkg::SACC_IDLE);
    assign conv_tick = cif.tick;
    sacc_clkgen #(
        .LOCAL_DIV (LOCAL_DIV)
    ) u_clkgen (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .alt_clk_sync (alt_sync_reg[1]),
        .cif          (cif)
    );
    sacc_sar #(
        .RES_W (RES_W)
    ) u_sar (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (smp_end),
        .abort   (abort),
        .tick    (conv_tick),
        .comp_in (cmp_sync_reg[1]),
        .trial   (sar_trial),
        .done    (sar_done),
        .result  (sar_result)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg      <= sacc_pkg::SACC_IDLE;
            smp_cnt_reg <= 4'h0;
        end else if (go) begin
            st_reg      <= sacc_pkg::SACC_SAMPLE;
            smp_cnt_reg <= smp_len;
        end else if (abort) begin
            st_reg <= sacc_pkg::SACC_IDLE;
        end else begin
            unique case (st_reg)
                sacc_pkg::SACC_IDLE: st_reg <= sacc_pkg::SACC_IDLE;
                sacc_pkg::SACC_SAMPLE: begin
                    if (smp_end) begin
                        st_reg <= sacc_pkg::SACC_APPROX;
                    end else if (conv_tick) begin
                        smp_cnt_reg <= smp_cnt_reg - 4'h1;
                    end
                end
                sacc_pkg::SACC_APPROX: begin
                    if (sar_done) begin
                        st_reg <= sacc_pkg::SACC_IDLE;
                    end
                end
                default: st_reg <= sacc_pkg::SACC_IDLE;
            endcase
        end
    end
    // =========================================
    // register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc1_reg      <= `SACC_SC1_RESET;
            sc2_reg      <= 8'h00;
            cfg_reg      <= 8'h00;
            cmp_reg      <= '0;
            res_reg      <= '0;
            hw_armed_reg <= 1'b0;
        end else begin
            if (wr_sc1) begin
                sc1_reg[6:0] <= w_data_reg[6:0];
                hw_armed_reg <= 1'b1;
            end else if (hw_start) begin
                hw_armed_reg <= 1'b0;
            end
            if (set_done) begin
                sc1_reg[`SACC_SC1_DONE] <= 1'b1;
            end else if (wr_sc1 || rd_lo) begin
                sc1_reg[`SACC_SC1_DONE] <= 1'b0;
            end
            if (wr_sc2) begin
                sc2_reg <= {1'b0, w_data_reg[6:4], 4'h0};
            end
            if (wr_cfg) begin
                cfg_reg <= w_data_reg[7:0];
            end
            if (wr_cmph) begin
                cmp_reg[9:8] <= w_data_reg[1:0];
            end
            if (wr_cmpl) begin
                cmp_reg[7:0] <= w_data_reg[7:0];
            end
            if (set_done) begin
                res_reg <= sar_result;
            end
        end
    end
    // =========================================
    // analog side outputs and interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_select <= `SACC_CH_OFF;
            sample_enable  <= 1'b0;
            long_sample    <= 1'b0;
            low_power      <= 1'b0;
            dac_trial      <= '0;
            conv_irq       <= 1'b0;
        end else begin
            channel_select <= sc1_reg[4:0];
            sample_enable  <= (st_reg == sacc_pkg::SACC_SAMPLE);
            long_sample    <= cfg_reg[`SACC_CFG_LONGSMP];
            low_power      <= cfg_reg[`SACC_CFG_LOWPWR];
            dac_trial      <= sar_trial;
            conv_irq       <= sc1_reg[`SACC_SC1_DONE] & sc1_reg[`SACC_SC1_IEN];
        end
    end
endmodule

// >>> sacc_top_sva.sv
// port checker for the converter control, bound to its top module
`timescale 1ns/100ps
`include "sacc_regs.svh"
module sacc_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [4:0]  channel_select,
    input wire logic        sample_enable,
    input wire logic        long_sample,
    input wire logic        low_power,
    input wire logic        conv_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wr_both;
    logic sc1_wr;
    logic cfg_wr;
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign sc1_wr  = wr_both && s_axi_wstrb[0] && s_axi_awaddr == `SACC_OFS_SC1;
    assign cfg_wr  = wr_both && s_axi_wstrb[0] && s_axi_awaddr == `SACC_OFS_CFG;
    // ========================================
    // bus handshake
    b_after_a: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    r_after_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    no_ready_pend_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // ========================================
    // register effects at the ports
    chan_follow_a: assert property (sc1_wr |-> ##3
        channel_select == $past(s_axi_wdata[4:0], 3))
        else $error("channel not taken from control write");
    off_nostart_a: assert property ($rose(sample_enable) |-> channel_select != `SACC_CH_OFF)
        else $error("sampling started with channel off");
    cfg_follow_a: assert property (cfg_wr |-> ##3 long_sample == $past(s_axi_wdata[4], 3)
        && low_power == $past(s_axi_wdata[7], 3)) else $error("sample or power setting wrong");
    irq_clear_a: assert property (sc1_wr && !s_axi_wdata[6] |-> ##[1:3] !conv_irq)
        else $error("interrupt stayed after control write");
    off_stop_a: assert property (sc1_wr && s_axi_wdata[4:0] == `SACC_CH_OFF
        |-> ##[1:4] !sample_enable) else $error("sampling not stopped by off write");
    cover property (sc1_wr);
    cover property ($rose(conv_irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind sacc_top sacc_top_sva sacc_top_sva_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .channel_select(channel_select),
    .sample_enable(sample_enable), .long_sample(long_sample), .low_power(low_power),
    .conv_irq(conv_irq));

// >>> sacc_far_model.sv
// far-side model: analog levels behind the comparator, overflow trigger, reference clock
`timescale 1ns/100ps
module sacc_far_model #(
    parameter real ALT_HALF_NS = 18.5
) (
    input  wire logic       aclk,
    input  wire logic [4:0] channel_select,
    input  wire logic [9:0] dac_trial,
    input  wire logic       overflow_req,
    output logic            comparator_in,
    output logic            hardware_trigger_input,
    output logic            alternate_clock_input
);
    logic [9:0] level;
    logic       idle_pat;
    // each channel holds code times 32 plus 21
    assign level = {channel_select, 5'h15};
    // disabled mux gives a toggling pattern, never a settled level
    assign comparator_in = (channel_select == 5'h1F) ? idle_pat : (level >= dac_trial);
    always @(posedge aclk) begin
        idle_pat <= ~idle_pat;
        // overflow reaches the trigger with no interrupt-enable gating
        hardware_trigger_input <= overflow_req;
    end
    initial begin
        idle_pat = 1'b0;
        hardware_trigger_input = 1'b0;
        alternate_clock_input = 1'b0;
        // free-running reference, also present in wait mode
        forever #(ALT_HALF_NS) alternate_clock_input = ~alternate_clock_input;
    end
endmodule

// >>> tb_top.sv
// self-checking bench: register traffic against the converter control
`timescale 1ns/100ps
`include "sacc_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic        aclk, awready, wready, bvalid, arready, rvalid, alt_clk, trig, comp;
    logic        smp, lsmp, lpwr, irq, got;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ovf_req = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cfg;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  chan;
    logic [9:0]  trial, want;
    logic [4:0]  chs [4] = '{5'h00, 5'h0F, 5'h1B, 5'h1A};
    logic [7:0]  cmps [3] = '{8'h16, 8'h16, 8'h15};
    logic [7:0]  sc2s [3] = '{8'h30, 8'h20, 8'h30};
    logic        cmpok [3] = '{1'b0, 1'b1, 1'b1};
    int          mismatches = 0;
    int          samples_checked = 0;
    int          i;
    sacc_top sacc_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .alternate_clock_input(alt_clk), .hardware_trigger_input(trig),
        .comparator_in(comp), .channel_select(chan), .sample_enable(smp),
        .long_sample(lsmp), .low_power(lpwr), .dac_trial(trial), .conv_irq(irq));
    sacc_far_model sacc_far_model_i (
        .aclk(aclk), .channel_select(chan), .dac_trial(trial), .overflow_req(ovf_req),
        .comparator_in(comp), .hardware_trigger_input(trig), .alternate_clock_input(alt_clk));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ========================================
    // bus tasks and helpers
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic hang;
        mismatches++;
        summarize();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        r = bresp;
        if (n >= 200) hang();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        d = rdata;
        r = rresp;
        if (n >= 200) hang();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        axr(a, rd, rs);
        `CHK(rd, e)
    endtask
    task automatic wait_done(input int lim, output logic f);
        int k;
        f = 1'b0;
        for (k = 0; k < lim && !f; k++) begin
            axr(`SACC_OFS_SC1, rd, rs);
            f = rd[7];
        end
    endtask
    function automatic logic [9:0] lvl(input logic [4:0] c);
        return {c, 5'h15};
    endfunction
    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdchk(`SACC_OFS_SC1, 32'h1F);
        rdchk(`SACC_OFS_SC2, 32'h00);
        rdchk(`SACC_OFS_CFG, 32'h00);
        axr(8'h1C, rd, rs);
        `CHK(rs, 2'b10)
        axw(8'h1C, 32'h0, rs);
        `CHK(rs, 2'b10)
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            cfg = {i[0], i[1:0], i[1], 1'b0, i == 3, i[1:0]};
            axw(`SACC_OFS_CFG, {24'h0, cfg}, rs);
            @(posedge aclk);
            `CHK({lpwr, lsmp}, {cfg[7], cfg[4]})
            axw(`SACC_OFS_SC1, 32'h0E, rs);
            axw(`SACC_OFS_SC1, {27'h0, chs[i]}, rs);
            wait_done(1000, got);
            `CHK(got, 1'b1)
            want = lvl(chs[i]);
            if (i == 3) want = want >> 2;
            rdchk(`SACC_OFS_RES_HI, {30'h0, want[9:8]});
            rdchk(`SACC_OFS_RES_LO, {24'h0, want[7:0]});
            rdchk(`SACC_OFS_SC2, 32'h00);
            rdchk(`SACC_OFS_SC1, {27'h0, chs[i]});
        end
        $display("test sources done");
        axw(`SACC_OFS_CFG, 32'h0, rs);
        axw(`SACC_OFS_CMP_HI, 32'h0, rs);
        for (i = 0; i < 3; i++) begin
            axw(`SACC_OFS_CMP_LO, {24'h0, cmps[i]}, rs);
            axw(`SACC_OFS_SC2, {24'h0, sc2s[i]}, rs);
            axw(`SACC_OFS_SC1, 32'h40, rs);
            wait_done(100, got);
            `CHK(got, cmpok[i])
            `CHK(irq, cmpok[i])
        end
        rdchk(`SACC_OFS_RES_LO, 32'h15);
        axw(`SACC_OFS_SC1, 32'h1F, rs);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        $display("test compare done");
        axw(`SACC_OFS_SC2, 32'h40, rs);
        axw(`SACC_OFS_SC1, 32'h0F, rs);
        wait_done(20, got);
        `CHK(got, 1'b0)
        ovf_req <= 1'b1;
        wait_done(200, got);
        `CHK(got, 1'b1)
        want = lvl(5'h0F);
        rdchk(`SACC_OFS_RES_LO, {24'h0, want[7:0]});
        wait_done(40, got);
        `CHK(got, 1'b0)
        ovf_req <= 1'b0;
        $display("test trigger done");
        axw(`SACC_OFS_SC2, 32'h0, rs);
        axw(`SACC_OFS_SC1, 32'h3B, rs);
        wait_done(200, got);
        `CHK(got, 1'b1)
        rdchk(`SACC_OFS_RES_LO, 32'h75);
        wait_done(200, got);
        `CHK(got, 1'b1)
        axw(`SACC_OFS_SC1, 32'h1F, rs);
        rdchk(`SACC_OFS_SC2, 32'h00);
        `CHK(smp, 1'b0)
        wait_done(30, got);
        `CHK(got, 1'b0)
        $display("test continuous done");
        summarize();
    end
endmodule
